// ### logic/awc_device.sv
// Purpose: Device end; decodes write commands and feeds sector words to media.
// Assumes: Block size comes from a separate configuration block; 256 words a sector.
// Notes: Task file writes are ignored while busy.
`timescale 1ns/100ps
module awc_device #(
	parameter logic [7:0] SECT_PER_TRACK = 8'h3F,
	parameter logic [3:0] LAST_HEAD = 4'hF
) (
	awc_link_if.dev lnk,
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] block_size,
	input wire logic media_uncorr,
	input wire logic media_flush_done,
	output logic [15:0] media_word_q,
	output logic media_wr_q,
	output logic [47:0] media_addr_q,
	output logic media_flush_q
);
	typedef enum logic [1:0] {D_IDLE, D_XFER, D_CHECK, D_FLUSH} awc_dstate_t;
	awc_dstate_t state_q;
	logic [7:0] cnt_q, cnt_p_q, sn_q, sn_p_q, cl_q, cl_p_q, ch_q, ch_p_q, dh_q;
	logic hob_q, busy_q, drq_q, err_q, idnf_q, abrt_q, intrq_q, ext_q, lba_q;
	logic [15:0] rdata_q;
	logic [47:0] addr_q;
	logic [16:0] remain_q;
	logic [7:0] word_q, blk_q;
	logic [7:0] stat_b, err_b, opc;
	logic wr, rd, cmd_acc, data_wr, fail;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Zero count stands for the largest transfer
	function automatic logic [16:0] count_of(input logic ext, input logic [7:0] p,
		input logic [7:0] c);
		if (ext) begin
			count_of = ({p, c} == 16'h0000) ? awc_pkg::ZERO_COUNT_EXT : {1'b0, p, c};
		end else begin
			count_of = (c == 8'h00) ? awc_pkg::ZERO_COUNT_28 : {9'h000, c};
		end
	endfunction : count_of

	// Next sector address in logical or cylinder/head/sector form
	function automatic logic [47:0] next_addr(input logic [47:0] a, input logic lba);
		logic [7:0] s;
		logic [3:0] h;
		logic [15:0] cy;
		s = a[7:0];
		h = a[27:24];
		cy = a[23:8];
		if (lba) begin
			next_addr = a + 48'h000000000001;
		end else begin
			if (s >= SECT_PER_TRACK) begin
				s = 8'h01;
				if (h >= LAST_HEAD) begin
					h = 4'h0;
					cy = cy + 16'h0001;
				end else begin
					h = h + 4'h1;
				end
			end else begin
				s = s + 8'h01;
			end
			next_addr = {a[47:28], h, cy, s};
		end
	endfunction : next_addr

	// ----------------------------------------
	// Link decode
	// ----------------------------------------
	assign wr = lnk.cs & lnk.we;
	assign rd = lnk.cs & ~lnk.we;
	assign cmd_acc = wr && (lnk.addr == awc_pkg::A_CMD) && !busy_q;
	assign data_wr = wr && (lnk.addr == awc_pkg::A_DATA) && drq_q;
	assign opc = lnk.wdata[7:0] & awc_pkg::CMD_RETRY_IGNORE;
	assign fail = media_uncorr;
	assign lnk.rdata = rdata_q;
	assign lnk.intrq = intrq_q;
	assign media_addr_q = addr_q;

	// Status and error bytes; unlisted bits stay zero
	always_comb begin
		stat_b = 8'h00;
		err_b = 8'h00;
		stat_b[awc_pkg::ST_BUSY] = busy_q;
		stat_b[awc_pkg::ST_READY] = 1'b1;
		stat_b[awc_pkg::ST_SEEK] = 1'b1;
		stat_b[awc_pkg::ST_DRQ] = drq_q;
		stat_b[awc_pkg::ST_ERR] = err_q;
		err_b[awc_pkg::ER_IDNF] = idnf_q;
		err_b[awc_pkg::ER_ABRT] = abrt_q;
	end

	// ----------------------------------------
	// Command block registers
	// ----------------------------------------
	// Host writes shift current into previous; device writes back results
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= 8'h00; cnt_p_q <= 8'h00; sn_q <= 8'h00; sn_p_q <= 8'h00;
			cl_q <= 8'h00; cl_p_q <= 8'h00; ch_q <= 8'h00; ch_p_q <= 8'h00;
			dh_q <= awc_pkg::DH_ONES;
			hob_q <= 1'b0;
		end else if (wr && !busy_q && !drq_q) begin
			if (lnk.addr == awc_pkg::A_DEVCTL) begin
				hob_q <= lnk.wdata[awc_pkg::CTL_HOB];
			end else if (lnk.addr >= awc_pkg::A_COUNT && lnk.addr <= awc_pkg::A_DEVHEAD) begin
				hob_q <= 1'b0;
			end
			if (lnk.addr == awc_pkg::A_COUNT) begin
				cnt_p_q <= cnt_q;
				cnt_q <= lnk.wdata[7:0];
			end else if (lnk.addr == awc_pkg::A_SECT) begin
				sn_p_q <= sn_q;
				sn_q <= lnk.wdata[7:0];
			end else if (lnk.addr == awc_pkg::A_CYLLO) begin
				cl_p_q <= cl_q;
				cl_q <= lnk.wdata[7:0];
			end else if (lnk.addr == awc_pkg::A_CYLHI) begin
				ch_p_q <= ch_q;
				ch_q <= lnk.wdata[7:0];
			end else if (lnk.addr == awc_pkg::A_DEVHEAD) begin
				dh_q <= lnk.wdata[7:0] | awc_pkg::DH_ONES;
			end
		end else if (state_q == D_CHECK && (!fail || ext_q)) begin
			// Last good sector, or failing sector for the extended command
			sn_q <= addr_q[7:0];
			cl_q <= addr_q[15:8];
			ch_q <= addr_q[23:16];
			if (ext_q) begin
				sn_p_q <= addr_q[31:24];
				cl_p_q <= addr_q[39:32];
				ch_p_q <= addr_q[47:40];
			end else begin
				dh_q[3:0] <= addr_q[27:24];
				cnt_q <= remain_q[7:0] - 8'h01;
			end
		end else if (state_q == D_CHECK && !ext_q) begin
			cnt_q <= remain_q[7:0];
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	// Status read drops the interrupt; a new set in the same cycle wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= D_IDLE;
			busy_q <= 1'b0; drq_q <= 1'b0; err_q <= 1'b0;
			idnf_q <= 1'b0; abrt_q <= 1'b0; intrq_q <= 1'b0;
			ext_q <= 1'b0; lba_q <= 1'b0;
			addr_q <= 48'h000000000000;
			remain_q <= 17'h00000;
			word_q <= 8'h00; blk_q <= 8'h00;
			media_word_q <= 16'h0000; media_wr_q <= 1'b0; media_flush_q <= 1'b0;
		end else begin
			media_wr_q <= 1'b0;
			if (rd && lnk.addr == awc_pkg::A_CMD) begin
				intrq_q <= 1'b0;
			end
			case (state_q)
				D_IDLE: begin
					if (cmd_acc) begin
						err_q <= 1'b0; idnf_q <= 1'b0; abrt_q <= 1'b0;
						word_q <= 8'h00; blk_q <= 8'h00;
						if (lnk.wdata[7:0] == awc_pkg::CMD_FUA_MULT_EXT && block_size != 8'h00) begin
							ext_q <= 1'b1;
							lba_q <= 1'b1;
							addr_q <= {ch_p_q, cl_p_q, sn_p_q, ch_q, cl_q, sn_q};
							remain_q <= count_of(1'b1, cnt_p_q, cnt_q);
							drq_q <= 1'b1;
							state_q <= D_XFER;
						end else if (opc == awc_pkg::CMD_WRITE_SECT) begin
							ext_q <= 1'b0;
							lba_q <= dh_q[awc_pkg::DH_LBA];
							addr_q <= {20'h00000, dh_q[3:0], ch_q, cl_q, sn_q};
							remain_q <= count_of(1'b0, cnt_p_q, cnt_q);
							drq_q <= 1'b1;
							state_q <= D_XFER;
						end else begin
							err_q <= 1'b1;
							abrt_q <= 1'b1;
							intrq_q <= 1'b1;
						end
					end
				end
				D_XFER: begin
					if (data_wr) begin
						media_word_q <= lnk.wdata;
						media_wr_q <= 1'b1;
						word_q <= word_q + 8'h01;
						if (word_q == awc_pkg::WORD_LAST) begin
							drq_q <= 1'b0;
							busy_q <= 1'b1;
							state_q <= D_CHECK;
						end
					end
				end
				D_CHECK: begin
					if (fail) begin
						err_q <= 1'b1;
						idnf_q <= 1'b1;
						busy_q <= 1'b0;
						intrq_q <= 1'b1;
						state_q <= D_IDLE;
					end else if (remain_q == 17'h00001) begin
						remain_q <= 17'h00000;
						if (ext_q) begin
							media_flush_q <= 1'b1;
							state_q <= D_FLUSH;
						end else begin
							busy_q <= 1'b0;
							intrq_q <= 1'b1;
							state_q <= D_IDLE;
						end
					end else begin
						remain_q <= remain_q - 17'h00001;
						addr_q <= next_addr(addr_q, lba_q);
						busy_q <= 1'b0;
						drq_q <= 1'b1;
						state_q <= D_XFER;
						if (!ext_q || blk_q + 8'h01 >= block_size) begin
							intrq_q <= 1'b1;
							blk_q <= 8'h00;
						end else begin
							blk_q <= blk_q + 8'h01;
						end
					end
				end
				D_FLUSH: begin
					if (media_flush_done) begin
						media_flush_q <= 1'b0;
						busy_q <= 1'b0;
						intrq_q <= 1'b1;
						state_q <= D_IDLE;
					end
				end
				default: state_q <= D_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// HIGH_ORDER_BYTE_SELECT selects the previous bytes of the shadow registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 16'h0000;
		end else if (rd) begin
			if (lnk.addr == awc_pkg::A_FEAT) begin
				rdata_q <= {8'h00, err_b};
			end else if (lnk.addr == awc_pkg::A_COUNT) begin
				rdata_q <= {8'h00, hob_q ? cnt_p_q : cnt_q};
			end else if (lnk.addr == awc_pkg::A_SECT) begin
				rdata_q <= {8'h00, hob_q ? sn_p_q : sn_q};
			end else if (lnk.addr == awc_pkg::A_CYLLO) begin
				rdata_q <= {8'h00, hob_q ? cl_p_q : cl_q};
			end else if (lnk.addr == awc_pkg::A_CYLHI) begin
				rdata_q <= {8'h00, hob_q ? ch_p_q : ch_q};
			end else if (lnk.addr == awc_pkg::A_DEVHEAD) begin
				rdata_q <= {8'h00, dh_q};
			end else if (lnk.addr == awc_pkg::A_CMD) begin
				rdata_q <= {8'h00, stat_b};
			end else begin
				rdata_q <= 16'h0000;
			end
		end
	end
endmodule : awc_device

// ### inc/awc_pkg.sv
// Purpose: Shared constants for the write-command handler link and controller.
// Assumes: One clock; link strobes are synchronous to it.
// Notes: Link addresses select command block registers of the device.
package awc_pkg;
	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_FUA_MULT_EXT = 8'hCE;
	localparam logic [7:0] CMD_WRITE_SECT = 8'h30;
	localparam logic [7:0] CMD_RETRY_IGNORE = 8'hFE;
	// ----------------------------------------
	// Link register addresses
	// ----------------------------------------
	localparam logic [3:0] A_DATA = 4'h0;
	localparam logic [3:0] A_FEAT = 4'h1;
	localparam logic [3:0] A_COUNT = 4'h2;
	localparam logic [3:0] A_SECT = 4'h3;
	localparam logic [3:0] A_CYLLO = 4'h4;
	localparam logic [3:0] A_CYLHI = 4'h5;
	localparam logic [3:0] A_DEVHEAD = 4'h6;
	localparam logic [3:0] A_CMD = 4'h7;
	localparam logic [3:0] A_DEVCTL = 4'h8;
	// ----------------------------------------
	// Bit positions and fixed values
	// ----------------------------------------
	localparam int ST_BUSY = 7;
	localparam int ST_READY = 6;
	localparam int ST_SEEK = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_ERR = 0;
	localparam int ER_IDNF = 4;
	localparam int ER_ABRT = 2;
	localparam int CTL_HOB = 7;
	localparam int DH_LBA = 6;
	localparam int DH_DRV = 4;
	localparam logic [7:0] DH_ONES = 8'hA0;
	localparam logic [7:0] HOB_SET = 8'h80;
	localparam logic [7:0] WORD_LAST = 8'hFF;
	localparam logic [16:0] ZERO_COUNT_EXT = 17'h10000;
	localparam logic [16:0] ZERO_COUNT_28 = 17'h00100;
	// ----------------------------------------
	// Controller register offsets
	// ----------------------------------------
	localparam logic [7:0] R_CTRL = 8'h00;
	localparam logic [7:0] R_OPCODE = 8'h04;
	localparam logic [7:0] R_LBA_LO = 8'h08;
	localparam logic [7:0] R_LBA_HI = 8'h0C;
	localparam logic [7:0] R_COUNT = 8'h10;
	localparam logic [7:0] R_DATA = 8'h14;
	localparam logic [7:0] R_STATUS = 8'h18;
	localparam logic [7:0] R_IRQ_STAT = 8'h1C;
	localparam logic [7:0] R_IRQ_MASK = 8'h20;
	localparam logic [7:0] R_RESULT0 = 8'h24;
	localparam logic [7:0] R_RESULT1 = 8'h28;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_BLOCK = 2;
	localparam logic [3:0] PROG_LAST = 4'hA;
	localparam logic [3:0] RB_LAST_28 = 4'h5;
	localparam logic [3:0] RB_LAST_EXT = 4'hA;
endpackage : awc_pkg

// ### inc/awc_link_if.sv
// Purpose: Command block register link between controller and device.
// Assumes: cs is a one-cycle strobe; read data is valid one cycle after it.
// Notes: intrq is a level held by the device until status is read.
`timescale 1ns/100ps
interface awc_link_if;
	logic cs;
	logic we;
	logic [3:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic intrq;
	modport dev (input cs, input we, input addr, input wdata, output rdata, output intrq);
	modport hst (output cs, output we, output addr, output wdata, input rdata, input intrq);
endinterface : awc_link_if

// ### logic/awc_host.sv
// Purpose: Host end; APB-programmed controller that issues write commands.
// Assumes: Software fills OPCODE, LBA, COUNT then sets start; data via DATA.
// Notes: DATA writes stall on pready while the one-word buffer is full.
`timescale 1ns/100ps
module awc_host (
	awc_link_if.hst lnk,
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	output logic irq_q
);
	typedef enum logic [2:0] {H_IDLE, H_PROG, H_POLL, H_W1, H_W2, H_RB} awc_hstate_t;
	awc_hstate_t state_q;
	logic [7:0] opcode_q, dstat_q;
	logic [47:0] lba_q;
	logic [15:0] count_q, dbuf_q;
	logic lba_mode_q, drv_q, dbuf_full_q, rb_q, intrq_d_q;
	logic [2:0] stat_q, mask_q, clr_q;
	logic [3:0] step_q;
	logic [7:0] res_q [0:10];
	logic cs_q, we_q;
	logic [3:0] addr_q;
	logic [15:0] wdata_q;
	logic take, start_go, data_go, ext, dbusy, ddrq;
	logic [2:0] ev;
	logic [7:0] dh_b;
	logic [12:0] rb;

	assign take = psel & penable & pready_q;
	assign start_go = take && pwrite && paddr == awc_pkg::R_CTRL && pwdata[0] && state_q == H_IDLE;
	assign ext = opcode_q == awc_pkg::CMD_FUA_MULT_EXT;
	assign dbusy = lnk.rdata[awc_pkg::ST_BUSY];
	assign ddrq = lnk.rdata[awc_pkg::ST_DRQ];
	assign data_go = state_q == H_W2 && !rb_q && !dbusy && ddrq && dbuf_full_q;
	assign dh_b = awc_pkg::DH_ONES | {1'b0, lba_mode_q | ext, 1'b0, drv_q, ext ? 4'h0 : lba_q[27:24]};
	assign rb = rb_op(step_q);
	assign lnk.cs = cs_q;
	assign lnk.we = we_q;
	assign lnk.addr = addr_q;
	assign lnk.wdata = wdata_q;

	// Programming sequence; for 28-bit the previous slots repeat the current byte
	function automatic logic [11:0] prog_op(input logic [3:0] s);
		case (s)
			4'h0: prog_op = {awc_pkg::A_DEVCTL, 8'h00};
			4'h1: prog_op = {awc_pkg::A_COUNT, ext ? count_q[15:8] : count_q[7:0]};
			4'h2: prog_op = {awc_pkg::A_COUNT, count_q[7:0]};
			4'h3: prog_op = {awc_pkg::A_SECT, ext ? lba_q[31:24] : lba_q[7:0]};
			4'h4: prog_op = {awc_pkg::A_SECT, lba_q[7:0]};
			4'h5: prog_op = {awc_pkg::A_CYLLO, ext ? lba_q[39:32] : lba_q[15:8]};
			4'h6: prog_op = {awc_pkg::A_CYLLO, lba_q[15:8]};
			4'h7: prog_op = {awc_pkg::A_CYLHI, ext ? lba_q[47:40] : lba_q[23:16]};
			4'h8: prog_op = {awc_pkg::A_CYLHI, lba_q[23:16]};
			4'h9: prog_op = {awc_pkg::A_DEVHEAD, dh_b};
			default: prog_op = {awc_pkg::A_CMD, opcode_q};
		endcase
	endfunction : prog_op

	// Readback sequence: {write, address, data}
	function automatic logic [12:0] rb_op(input logic [3:0] s);
		case (s)
			4'h0: rb_op = {1'b0, awc_pkg::A_FEAT, 8'h00};
			4'h1: rb_op = {1'b0, awc_pkg::A_COUNT, 8'h00};
			4'h2: rb_op = {1'b0, awc_pkg::A_SECT, 8'h00};
			4'h3: rb_op = {1'b0, awc_pkg::A_CYLLO, 8'h00};
			4'h4: rb_op = {1'b0, awc_pkg::A_CYLHI, 8'h00};
			4'h5: rb_op = {1'b0, awc_pkg::A_DEVHEAD, 8'h00};
			4'h6: rb_op = {1'b1, awc_pkg::A_DEVCTL, awc_pkg::HOB_SET};
			4'h7: rb_op = {1'b0, awc_pkg::A_SECT, 8'h00};
			4'h8: rb_op = {1'b0, awc_pkg::A_CYLLO, 8'h00};
			4'h9: rb_op = {1'b0, awc_pkg::A_CYLHI, 8'h00};
			default: rb_op = {1'b1, awc_pkg::A_DEVCTL, 8'h00};
		endcase
	endfunction : rb_op

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// pready follows one cycle after the access phase; DATA waits for room
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pready_q <= 1'b0; pslverr_q <= 1'b0; prdata_q <= 32'h00000000;
			opcode_q <= 8'h00; lba_q <= 48'h000000000000; count_q <= 16'h0000;
			lba_mode_q <= 1'b0; drv_q <= 1'b0; mask_q <= 3'h0; clr_q <= 3'h0;
			dbuf_q <= 16'h0000;
		end else if (take) begin
			pready_q <= 1'b0;
			if (pwrite) begin
				if (paddr == awc_pkg::R_CTRL) begin
					lba_mode_q <= pwdata[1];
					drv_q <= pwdata[2];
				end else if (paddr == awc_pkg::R_OPCODE) begin
					opcode_q <= pwdata[7:0];
				end else if (paddr == awc_pkg::R_LBA_LO) begin
					lba_q[31:0] <= pwdata;
				end else if (paddr == awc_pkg::R_LBA_HI) begin
					lba_q[47:32] <= pwdata[15:0];
				end else if (paddr == awc_pkg::R_COUNT) begin
					count_q <= pwdata[15:0];
				end else if (paddr == awc_pkg::R_DATA) begin
					dbuf_q <= pwdata[15:0];
				end else if (paddr == awc_pkg::R_IRQ_MASK) begin
					mask_q <= pwdata[2:0];
				end
			end
		end else if (psel && penable && !(pwrite && paddr == awc_pkg::R_DATA && dbuf_full_q)) begin
			pready_q <= 1'b1;
			pslverr_q <= paddr > awc_pkg::R_RESULT1 || paddr[1:0] != 2'b00;
			clr_q <= (!pwrite && paddr == awc_pkg::R_IRQ_STAT) ? stat_q : 3'h0;
			if (pwrite) begin
				prdata_q <= 32'h00000000;
			end else if (paddr == awc_pkg::R_CTRL) begin
				prdata_q <= {29'h0, drv_q, lba_mode_q, 1'b0};
			end else if (paddr == awc_pkg::R_OPCODE) begin
				prdata_q <= {24'h0, opcode_q};
			end else if (paddr == awc_pkg::R_LBA_LO) begin
				prdata_q <= lba_q[31:0];
			end else if (paddr == awc_pkg::R_LBA_HI) begin
				prdata_q <= {16'h0, lba_q[47:32]};
			end else if (paddr == awc_pkg::R_COUNT) begin
				prdata_q <= {16'h0, count_q};
			end else if (paddr == awc_pkg::R_STATUS) begin
				prdata_q <= {res_q[1], res_q[0], dstat_q, 6'h0, dbuf_full_q, state_q != H_IDLE};
			end else if (paddr == awc_pkg::R_IRQ_STAT) begin
				prdata_q <= {29'h0, stat_q};
			end else if (paddr == awc_pkg::R_IRQ_MASK) begin
				prdata_q <= {29'h0, mask_q};
			end else if (paddr == awc_pkg::R_RESULT0) begin
				prdata_q <= {res_q[5], res_q[4], res_q[3], res_q[2]};
			end else if (paddr == awc_pkg::R_RESULT1) begin
				prdata_q <= {8'h00, res_q[9], res_q[8], res_q[7]};
			end else begin
				prdata_q <= 32'h00000000;
			end
		end
	end

	// Data word buffer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			dbuf_full_q <= 1'b0;
		end else if (take && pwrite && paddr == awc_pkg::R_DATA) begin
			dbuf_full_q <= 1'b1;
		end else if (data_go || state_q == H_IDLE) begin
			dbuf_full_q <= 1'b0;
		end
	end

	// Sticky events; read clears only what was read, new events win
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stat_q <= 3'h0;
			irq_q <= 1'b0;
			intrq_d_q <= 1'b0;
		end else begin
			intrq_d_q <= lnk.intrq;
			stat_q <= (stat_q & ~(take ? clr_q : 3'h0)) | ev;
			irq_q <= |(stat_q & mask_q);
		end
	end

	// Events; done fires on the last readback step, a read or the closing write
	always_comb begin
		ev = 3'h0;
		ev[awc_pkg::IRQ_BLOCK] = lnk.intrq & ~intrq_d_q;
		ev[awc_pkg::IRQ_DONE] = rb_q &&
			step_q == (ext ? awc_pkg::RB_LAST_EXT : awc_pkg::RB_LAST_28) &&
			((state_q == H_W2 && !rb[12]) || (state_q == H_RB && rb[12]));
		ev[awc_pkg::IRQ_ERR] = ev[awc_pkg::IRQ_DONE] && dstat_q[awc_pkg::ST_ERR];
	end

	// ----------------------------------------
	// Link sequencer
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= H_IDLE; step_q <= 4'h0; rb_q <= 1'b0; dstat_q <= 8'h00;
			cs_q <= 1'b0; we_q <= 1'b0; addr_q <= 4'h0; wdata_q <= 16'h0000;
			for (int i = 0; i <= 10; i++) begin
				res_q[i] <= 8'h00;
			end
		end else begin
			cs_q <= 1'b0;
			case (state_q)
				H_IDLE: begin
					step_q <= 4'h0;
					rb_q <= 1'b0;
					if (start_go) begin
						state_q <= H_PROG;
					end
				end
				H_PROG: begin
					cs_q <= 1'b1;
					we_q <= 1'b1;
					{addr_q, wdata_q[7:0]} <= prog_op(step_q);
					wdata_q[15:8] <= 8'h00;
					step_q <= step_q + 4'h1;
					if (step_q == awc_pkg::PROG_LAST) begin
						state_q <= H_POLL;
					end
				end
				H_POLL: begin
					cs_q <= 1'b1;
					we_q <= 1'b0;
					addr_q <= awc_pkg::A_CMD;
					state_q <= H_W1;
				end
				H_W1: state_q <= H_W2;
				H_W2: begin
					if (rb_q) begin
						res_q[step_q] <= lnk.rdata[7:0];
						if (step_q == (ext ? awc_pkg::RB_LAST_EXT : awc_pkg::RB_LAST_28)) begin
							state_q <= H_IDLE;
						end else begin
							step_q <= step_q + 4'h1;
							state_q <= H_RB;
						end
					end else begin
						dstat_q <= lnk.rdata[7:0];
						state_q <= H_POLL;
						if (data_go) begin
							cs_q <= 1'b1;
							we_q <= 1'b1;
							addr_q <= awc_pkg::A_DATA;
							wdata_q <= dbuf_q;
						end else if (!dbusy && !ddrq) begin
							rb_q <= 1'b1;
							step_q <= 4'h0;
							state_q <= H_RB;
						end
					end
				end
				H_RB: begin
					cs_q <= 1'b1;
					{we_q, addr_q, wdata_q[7:0]} <= rb;
					wdata_q[15:8] <= 8'h00;
					if (rb[12]) begin
						if (step_q == (ext ? awc_pkg::RB_LAST_EXT : awc_pkg::RB_LAST_28)) begin
							state_q <= H_IDLE;
						end else begin
							step_q <= step_q + 4'h1;
						end
					end else begin
						state_q <= H_W1;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end
endmodule : awc_host

// ### verif/awc_link_assertions.sv
// Purpose: Timing checks on the link between host and device ends
// Assumes: One clock, reset active low
// Notes: Takes the link signals as plain inputs
`timescale 1ns/100ps
module awc_link_assertions (
	input wire logic clk,
	input wire logic nrst,
	input wire logic cs,
	input wire logic we,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] rdata,
	input wire logic intrq
);
	// ------------
	// Link checks
	// ------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// Write strobe
	wire wr = cs && we;
	a_cs_pulse: assert property (cs && !we |=> !cs) else $error("read not spaced");
	a_addr_range: assert property (cs |-> addr <= 4'h8) else $error("bad address");
	a_devhead_ones: assert property (wr && addr == 4'h6 |-> wdata[7] && wdata[5])
		else $error("devhead fixed ones");
	a_cmd_after_dh: assert property (wr && addr == 4'h7 |-> $past(wr && addr == 4'h6))
		else $error("command order");
	a_count_pair: assert property (wr && addr == 4'h2 |->
		$past(wr && addr == 4'h2) or ##1 (wr && addr == 4'h2)) else $error("count pair");
	a_intrq_clear: assert property ($fell(intrq) |-> $past(cs && !we && addr == 4'h7))
		else $error("intrq dropped");
	a_rdata_hold: assert property ($changed(rdata) |-> $past(cs && !we))
		else $error("rdata moved");
	a_hob_restore: assert property (wr && addr == 4'h8 && wdata[7] |->
		##[1:40] (wr && addr == 4'h8 && !wdata[7])) else $error("hob left set");
endmodule : awc_link_assertions

// ### verif/ata_write_command_handler_tb.sv
// Purpose: End to end bench, APB host to device media side
// Assumes: 40 MHz clock, 256 words a sector
// Notes: Media stand-in fails a sector on request
`timescale 1ns/100ps
module ata_write_command_handler_tb;
	logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sl;
	logic [7:0] paddr = 8'h00, bsize = 8'h01;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq, uncorr = 1'b0, fdone = 1'b0, mwr, mflush;
	logic [15:0] mword;
	logic [47:0] maddr;
	int num_errors = 0, checks_done = 0, nwr = 0, fth = 32'h7FFFFFFF;
	awc_link_if lnk ();
	awc_host u_awc_host (.lnk(lnk), .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata),
		.pready_q(pready), .pslverr_q(pslverr), .irq_q(irq));
	awc_device u_awc_device (.lnk(lnk), .clk(clk), .nrst(nrst), .block_size(bsize),
		.media_uncorr(uncorr), .media_flush_done(fdone), .media_word_q(mword),
		.media_wr_q(mwr), .media_addr_q(maddr), .media_flush_q(mflush));
	awc_link_assertions u_awc_link_assertions (.clk(clk), .nrst(nrst), .cs(lnk.cs),
		.we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .intrq(lnk.intrq));
	// Clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Media stand-in: counts words, fails past a threshold, acknowledges flush
	always @(posedge clk) begin
		nwr <= nwr + int'(mwr);
		uncorr <= nwr > fth;
		fdone <= mflush;
	end
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic hang();
		num_errors++;
		$display("ERROR %0t wait ran out", $time);
		tally_and_finish();
	endtask : hang
	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
		checks_done++;
		if ((g & m) !== (e & m)) begin
			num_errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : cmp
	// One APB transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 2000);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 2000)
			hang();
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		apb(1'b0, a, 32'h0);
		cmp(rd, e, m);
	endtask : rdc
	// Programs and starts a command, streams words, waits for idle
	task automatic run(input logic [7:0] op, input logic [47:0] lba, input logic [15:0] cnt,
		input int words);
		int n0;
		int n;
		n0 = nwr;
		n = 0;
		apb(1'b1, awc_pkg::R_OPCODE, {24'h0, op});
		apb(1'b1, awc_pkg::R_LBA_LO, lba[31:0]);
		apb(1'b1, awc_pkg::R_LBA_HI, {16'h0, lba[47:32]});
		apb(1'b1, awc_pkg::R_COUNT, {16'h0, cnt});
		apb(1'b1, awc_pkg::R_CTRL, 32'h3);
		for (int i = 0; i < words; i++)
			apb(1'b1, awc_pkg::R_DATA, 32'(i));
		do begin
			apb(1'b0, awc_pkg::R_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 500);
		if (n >= 500)
			hang();
		cmp(32'(nwr - n0), 32'(words), 32'hFFFFFFFF);
		if (words > 0)
			cmp({16'h0, mword}, 32'(words - 1), 32'hFFFF);
	endtask : run
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		apb(1'b1, awc_pkg::R_IRQ_MASK, 32'h1);
		run(8'h31, 48'h1234567, 16'h1, 256);
		cmp(maddr[31:0], 32'h1234567, 32'hFFFFFFFF);
		rdc(awc_pkg::R_STATUS, 32'h00005000, 32'hFFFFFF03);
		rdc(awc_pkg::R_RESULT0, 32'hE1234567, 32'hFFFFFFFF);
		cmp({31'h0, irq}, 32'h1, 32'h1);
		rdc(awc_pkg::R_IRQ_STAT, 32'h1, 32'h3);
		repeat (2) @(posedge clk);
		cmp({31'h0, irq}, 32'h0, 32'h1);
		fth = nwr + 256;
		run(8'h30, 48'h10, 16'h3, 512);
		rdc(awc_pkg::R_STATUS, 32'h02105100, 32'hFFFFFF03);
		rdc(awc_pkg::R_RESULT0, 32'hE0000010, 32'hFFFFFFFF);
		rdc(awc_pkg::R_IRQ_STAT, 32'h7, 32'h7);
		fth = 32'h7FFFFFFF;
		run(8'hCE, 48'h20, 16'h2, 512);
		rdc(awc_pkg::R_STATUS, 32'h02005000, 32'hFFFFFF03);
		rdc(awc_pkg::R_IRQ_STAT, 32'h5, 32'h5);
		bsize <= 8'h00;
		run(8'hCE, 48'h0, 16'h1, 0);
		rdc(awc_pkg::R_STATUS, 32'h00040100, 32'h00FF0100);
		bsize <= 8'h02;
		fth = nwr + 256;
		run(8'hCE, 48'h123456789ABC, 16'h2, 512);
		rdc(awc_pkg::R_STATUS, 32'h00100100, 32'h00FF0100);
		rdc(awc_pkg::R_RESULT0, 32'h00789ABD, 32'h00FFFFFF);
		rdc(awc_pkg::R_RESULT1, 32'h00123456, 32'h00FFFFFF);
		apb(1'b0, 8'h40, 32'h0);
		cmp({31'h0, sl}, 32'h1, 32'h1);
		tally_and_finish();
	end
endmodule : ata_write_command_handler_tb
